// file: scs_pkg.sv
// Shared constants, payload struct and link state type for the config slave
package scs_pkg;

   // Width of a configuration byte offset
   localparam int OFS_W = 7;
   // Bit of the command code that selects indexed against block access
   localparam int CMD_KIND_BIT = 7;
   // Number of configuration bytes an offset can reach
   localparam int CFG_BYTES = 128;
   // Value of every configuration byte after reset
   localparam logic [7:0] CFG_RESET = 8'h00;
   // Offset at which block transfers begin
   localparam logic [6:0] BLOCK_OFS = 7'h00;
   // Most data bytes an indexed write may carry (low and high of a word)
   localparam logic [7:0] INDEXED_MAX = 8'h02;
   // Bit counter value on the last data bit and in the acknowledge slot
   localparam logic [3:0] LAST_BIT = 4'h7;
   localparam logic [3:0] ACK_SLOT = 4'h8;
   // Synchroniser depths: pins pass three stages, the reset level two
   localparam int PIN_STAGES = 3;
   localparam int RST_STAGES = 2;
   // Default depth of the write buffer between the domains
   localparam int FIFO_DEPTH = 16;

   // One accepted configuration write
   typedef struct packed {
      logic [6:0] ofs;
      logic [7:0] data;
   } scs_wr_t;

   // Progress of the serial engine through a transaction
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_CMD,
      ST_WR,
      ST_TX,
      ST_IGNORE
   } scs_state_t;

endpackage : scs_pkg

// file: scs_sync.sv
// Multi-stage synchroniser that exposes its last two stages
`timescale 1ns/1ps
module scs_sync #(
   parameter int WIDTH  = 1,
   parameter int STAGES = 2
) (
   input  wire logic             clk,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q,
   output logic      [WIDTH-1:0] q_prev
);

   logic [WIDTH-1:0] stage [STAGES];

   // Shift chain; the first stage feeds the second, and is also q_prev when STAGES is 2
   always_ff @(posedge clk) begin
      stage[0] <= d;
      for (int i = 1; i < STAGES; i++) begin
         stage[i] <= stage[i-1];
      end
   end

   assign q      = stage[STAGES-1];
   assign q_prev = stage[STAGES-2];

endmodule : scs_sync

// file: scs_fifo.sv
// Dual-clock FIFO with gray-coded pointers and valid/ready on both sides
`timescale 1ns/1ps
module scs_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             wr_clk,
   input  wire logic             wr_rst,
   input  wire logic             wr_valid,
   output logic                  wr_ready,
   input  wire logic [WIDTH-1:0] wr_data,
   input  wire logic             rd_clk,
   input  wire logic             rd_rst,
   output logic                  rd_valid,
   input  wire logic             rd_ready,
   output logic      [WIDTH-1:0] rd_data
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wbin;
   logic [AW:0]      wgray;
   logic [AW:0]      rbin;
   logic [AW:0]      rgray;
   logic [AW:0]      rg_s1;
   logic [AW:0]      rg_s2;
   logic [AW:0]      wg_s1;
   logic [AW:0]      wg_s2;
   logic [AW:0]      wbin_nx;
   logic [AW:0]      rbin_nx;

   assign wbin_nx  = wbin + (AW+1)'(1);
   assign rbin_nx  = rbin + (AW+1)'(1);
   // Full when the write pointer is one lap ahead of the read pointer
   assign wr_ready = (wgray != {~rg_s2[AW:AW-1], rg_s2[AW-2:0]});
   assign rd_valid = (rgray != wg_s2);
   assign rd_data  = mem[rbin[AW-1:0]];

   // Write side pointer and storage
   always_ff @(posedge wr_clk) begin
      if (wr_rst) begin
         wbin  <= '0;
         wgray <= '0;
      end else if (wr_valid && wr_ready) begin
         mem[wbin[AW-1:0]] <= wr_data;
         wbin              <= wbin_nx;
         wgray             <= wbin_nx ^ (wbin_nx >> 1);
      end
   end

   // Read pointer seen in the write domain
   always_ff @(posedge wr_clk) begin
      if (wr_rst) begin
         rg_s1 <= '0;
         rg_s2 <= '0;
      end else begin
         rg_s1 <= rgray;
         rg_s2 <= rg_s1;
      end
   end

   // Read side pointer
   always_ff @(posedge rd_clk) begin
      if (rd_rst) begin
         rbin  <= '0;
         rgray <= '0;
      end else if (rd_valid && rd_ready) begin
         rbin  <= rbin_nx;
         rgray <= rbin_nx ^ (rbin_nx >> 1);
      end
   end

   // Write pointer seen in the read domain
   always_ff @(posedge rd_clk) begin
      if (rd_rst) begin
         wg_s1 <= '0;
         wg_s2 <= '0;
      end else begin
         wg_s1 <= wgray;
         wg_s2 <= wg_s1;
      end
   end

endmodule : scs_fifo

// file: scs_config_slave.sv
// Two-wire configuration slave: serial engine, byte store, write stream
`timescale 1ns/1ps
module scs_config_slave #(
   parameter logic [6:0] SLAVE_ADDR  = 7'h2a,  // Arbitrary bus address
   parameter logic [7:0] BLOCK_COUNT = 8'h08,  // Byte count of block read
   parameter int         DEPTH       = scs_pkg::FIFO_DEPTH
) (
   input  wire logic            clk_sys,
   input  wire logic            sys_rst,
   input  wire logic            clk_link,
   input  wire logic            scl,
   input  wire logic            sda_i,
   output logic                 sda_o,
   output logic                 sda_oe,
   output logic                 cfg_wr_valid,
   output scs_pkg::scs_wr_t     cfg_wr,
   input  wire logic            cfg_wr_ready
);

   // Link-domain reset and filtered pins
   logic                  link_rst;
   logic [1:0]            pin_q;
   logic [1:0]            pin_prev;
   logic                  scl_f;
   logic                  sda_f;
   logic                  scl_p;
   logic                  sda_p;

   // Serial engine state
   scs_pkg::scs_state_t   st;
   logic [3:0]            bit_cnt;
   logic [7:0]            shreg;
   logic                  ack_ok;
   logic                  blk;
   logic                  cnt_seen;
   logic [7:0]            cnt_val;
   logic [7:0]            wr_idx;
   logic [6:0]            ptr;
   logic [7:0]            cfg_mem [scs_pkg::CFG_BYTES];

   // Buffer interface
   logic                  push;
   scs_pkg::scs_wr_t      push_data;
   logic                  fifo_wr_ready;
   logic                  fifo_rd_valid;
   logic                  fifo_rd_ready;
   scs_pkg::scs_wr_t      fifo_rd_data;

   // Decoded events and helpers
   logic                  ev_start;
   logic                  ev_stop;
   logic                  ev_rise;
   logic                  ev_fall;
   logic [7:0]            byte_in;
   logic                  last_bit;
   logic                  data_room;
   logic                  wr_take;
   logic                  rx_ack;
   logic [7:0]            tx_next;

   // Reset level carried into the link domain
   scs_sync #(
      .WIDTH  (1),
      .STAGES (scs_pkg::RST_STAGES)
   ) u_rst_sync (
      .clk    (clk_link),
      .d      (sys_rst),
      .q      (link_rst),
      .q_prev ()
   );

   // Clock and data pins pass three stages
   scs_sync #(
      .WIDTH  (2),
      .STAGES (scs_pkg::PIN_STAGES)
   ) u_pin_sync (
      .clk    (clk_link),
      .d      ({scl, sda_i}),
      .q      (pin_q),
      .q_prev (pin_prev)
   );

   // A pin change counts once the last two stages agree
   always_ff @(posedge clk_link) begin
      if (link_rst) begin
         scl_f <= 1'b1;
         sda_f <= 1'b1;
         scl_p <= 1'b1;
         sda_p <= 1'b1;
      end else begin
         if (pin_q[1] == pin_prev[1]) begin
            scl_f <= pin_q[1];
         end
         if (pin_q[0] == pin_prev[0]) begin
            sda_f <= pin_q[0];
         end
         scl_p <= scl_f;
         sda_p <= sda_f;
      end
   end

   // Bus conditions and clock edges
   assign ev_start = scl_f && scl_p && sda_p && !sda_f;
   assign ev_stop  = scl_f && scl_p && !sda_p && sda_f;
   assign ev_rise  = scl_f && !scl_p;
   assign ev_fall  = !scl_f && scl_p;

   // Incoming byte, most significant bit first
   assign byte_in  = {shreg[6:0], sda_f};
   assign last_bit = ev_rise && (bit_cnt == scs_pkg::LAST_BIT);

   // Block writes are bounded by their count, indexed writes by a word
   assign data_room = blk ? (wr_idx < cnt_val)
                          : (wr_idx < scs_pkg::INDEXED_MAX);
   assign wr_take   = (st == scs_pkg::ST_WR) && last_bit
                      && !(blk && !cnt_seen) && data_room && fifo_wr_ready;

   // Acknowledge decision for the byte now completing
   always_comb begin
      case (st)
         scs_pkg::ST_ADDR: rx_ack = (byte_in[7:1] == SLAVE_ADDR);
         scs_pkg::ST_CMD:  rx_ack = 1'b1;
         scs_pkg::ST_WR:   rx_ack = (blk && !cnt_seen) || wr_take;
         default:          rx_ack = 1'b0;
      endcase
   end

   // Next byte to send: block count first, then bytes from the pointer
   assign tx_next = (blk && !cnt_seen) ? BLOCK_COUNT : cfg_mem[ptr];

   // Serial engine: bit counting, byte decode and transaction sequencing
   always_ff @(posedge clk_link) begin
      if (link_rst) begin
         st       <= scs_pkg::ST_IDLE;
         bit_cnt  <= '0;
         shreg    <= '0;
         ack_ok   <= 1'b0;
         blk      <= 1'b0;
         cnt_seen <= 1'b0;
         cnt_val  <= '0;
         wr_idx   <= '0;
         ptr      <= '0;
      end else if (ev_start) begin
         // Offset and access kind survive a repeated start
         st      <= scs_pkg::ST_ADDR;
         bit_cnt <= '0;
      end else if (ev_stop) begin
         st      <= scs_pkg::ST_IDLE;
         bit_cnt <= '0;
      end else if (ev_rise && st != scs_pkg::ST_IDLE
                   && st != scs_pkg::ST_IGNORE) begin
         if (bit_cnt != scs_pkg::ACK_SLOT) begin
            shreg   <= byte_in;
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == scs_pkg::LAST_BIT) begin
               ack_ok <= rx_ack;
            end
         end else begin
            bit_cnt <= '0;
            case (st)
               scs_pkg::ST_ADDR: begin
                  if (!ack_ok) begin
                     st <= scs_pkg::ST_IGNORE;
                  end else if (shreg[0]) begin
                     // Read address: present the first byte
                     st    <= scs_pkg::ST_TX;
                     shreg <= tx_next;
                     if (blk && !cnt_seen) begin
                        cnt_seen <= 1'b1;
                     end else begin
                        ptr <= ptr + 7'h01;
                     end
                  end else begin
                     st <= scs_pkg::ST_CMD;
                  end
               end
               scs_pkg::ST_CMD: begin
                  // Top bit picks the access kind; block ignores offset
                  blk      <= !shreg[scs_pkg::CMD_KIND_BIT];
                  ptr      <= shreg[scs_pkg::CMD_KIND_BIT]
                              ? shreg[scs_pkg::OFS_W-1:0]
                              : scs_pkg::BLOCK_OFS;
                  cnt_seen <= 1'b0;
                  wr_idx   <= '0;
                  st       <= scs_pkg::ST_WR;
               end
               scs_pkg::ST_WR: begin
                  if (!ack_ok) begin
                     st <= scs_pkg::ST_IGNORE;
                  end else if (blk && !cnt_seen) begin
                     cnt_val  <= shreg;
                     cnt_seen <= 1'b1;
                  end else begin
                     // Next byte lands at the next higher offset
                     wr_idx <= wr_idx + 8'h01;
                     ptr    <= ptr + 7'h01;
                  end
               end
               scs_pkg::ST_TX: begin
                  if (sda_f) begin
                     // Not-acknowledge ends the read
                     st <= scs_pkg::ST_IGNORE;
                  end else begin
                     shreg <= tx_next;
                     if (blk && !cnt_seen) begin
                        cnt_seen <= 1'b1;
                     end else begin
                        ptr <= ptr + 7'h01;
                     end
                  end
               end
               default: st <= scs_pkg::ST_IDLE;
            endcase
         end
      end
   end

   // Data pin drive changes only while the clock is low
   always_ff @(posedge clk_link) begin
      if (link_rst || ev_start || ev_stop) begin
         sda_oe <= 1'b0;
      end else if (ev_fall) begin
         case (st)
            scs_pkg::ST_TX: begin
               sda_oe <= (bit_cnt != scs_pkg::ACK_SLOT) && !shreg[7];
            end
            scs_pkg::ST_ADDR, scs_pkg::ST_CMD, scs_pkg::ST_WR: begin
               sda_oe <= (bit_cnt == scs_pkg::ACK_SLOT) && ack_ok;
            end
            default: sda_oe <= 1'b0;
         endcase
      end
   end

   // Open-drain data: the driven level is always low
   always_ff @(posedge clk_link) begin
      sda_o <= 1'b0;
   end

   // Configuration byte store read back by the link
   always_ff @(posedge clk_link) begin
      if (link_rst) begin
         for (int i = 0; i < scs_pkg::CFG_BYTES; i++) begin
            cfg_mem[i] <= scs_pkg::CFG_RESET;
         end
      end else if (wr_take) begin
         cfg_mem[ptr] <= byte_in;
      end
   end

   // Accepted writes queued toward the system domain
   always_ff @(posedge clk_link) begin
      if (link_rst) begin
         push      <= 1'b0;
         push_data <= '0;
      end else begin
         push      <= wr_take;
         push_data <= '{ofs: ptr, data: byte_in};
      end
   end

   scs_fifo #(
      .WIDTH    ($bits(scs_pkg::scs_wr_t)),
      .DEPTH    (DEPTH)
   ) u_fifo (
      .wr_clk   (clk_link),
      .wr_rst   (link_rst),
      .wr_valid (push),
      .wr_ready (fifo_wr_ready),
      .wr_data  (push_data),
      .rd_clk   (clk_sys),
      .rd_rst   (sys_rst),
      .rd_valid (fifo_rd_valid),
      .rd_ready (fifo_rd_ready),
      .rd_data  (fifo_rd_data)
   );

   // Output stage of the write stream toward device functions
   assign fifo_rd_ready = !cfg_wr_valid || cfg_wr_ready;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cfg_wr_valid <= 1'b0;
         cfg_wr       <= '0;
      end else if (fifo_rd_valid && fifo_rd_ready) begin
         cfg_wr_valid <= 1'b1;
         cfg_wr       <= fifo_rd_data;
      end else if (cfg_wr_ready) begin
         cfg_wr_valid <= 1'b0;
      end
   end

endmodule : scs_config_slave

// file: scs_config_slave_properties.sv
// Checker for the config slave's data pin and write stream
`timescale 1ns/1ps
module scs_config_slave_properties (
   input wire logic             clk_sys,
   input wire logic             sys_rst,
   input wire logic             clk_link,
   input wire logic             scl,
   input wire logic             sda_i,
   input wire logic             sda_o,
   input wire logic             sda_oe,
   input wire logic             cfg_wr_valid,
   input wire scs_pkg::scs_wr_t cfg_wr,
   input wire logic             cfg_wr_ready
);
   // Pin side: the slave only pulls, and changes its pull only while the bus clock is low
   sda_low_a : assert property (
      @(posedge clk_link) disable iff (sys_rst) sda_o == 1'b0)
      else $error("Data drive value not low");
   oe_scl_low_a : assert property (
      @(posedge clk_link) disable iff (sys_rst) $changed(sda_oe) |-> !scl)
      else $error("Data pull changed with bus clock high");
   oe_steady_a : assert property (
      @(posedge clk_link) disable iff (sys_rst)
      scl && $past(scl) |-> $stable(sda_oe))
      else $error("Data pull moved during clock high");
   oe_late_a : assert property (
      @(posedge clk_link) disable iff (sys_rst)
      $rose(sda_oe) |-> !$past(scl, 3))
      else $error("Data pull began too soon after clock fall");
   oe_reset_a : assert property (
      @(posedge clk_link) disable iff (sys_rst) $fell(sys_rst) |-> !sda_oe)
      else $error("Data pull active out of reset");
   // Stream side: an offered entry stands until it is taken
   valid_hold_a : assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      cfg_wr_valid && !cfg_wr_ready |=> cfg_wr_valid)
      else $error("Stream valid dropped before taken");
   data_hold_a : assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      cfg_wr_valid && !cfg_wr_ready |=> $stable(cfg_wr))
      else $error("Stream entry changed before taken");
   stream_reset_a : assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      $fell(sys_rst) |-> !cfg_wr_valid)
      else $error("Stream valid out of reset");
   // Main scenarios reached
   cover property (@(posedge clk_sys) cfg_wr_valid && !cfg_wr_ready);
   cover property (@(posedge clk_sys) cfg_wr_valid && cfg_wr_ready);
   cover property (@(posedge clk_link) $rose(sda_oe));
endmodule : scs_config_slave_properties

bind scs_config_slave scs_config_slave_properties u_props (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_link(clk_link),
   .scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
   .cfg_wr_valid(cfg_wr_valid), .cfg_wr(cfg_wr),
   .cfg_wr_ready(cfg_wr_ready)
);

// file: scs_host.sv
// Bus host model: start, stop, byte write and byte read at bit level
`timescale 1ns/1ps
module scs_host (
   input wire logic sda_line,
   output logic     scl,
   output logic     sda_m
);
   // Both lines released while idle; clock stands still between frames
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   // Start or repeated start: data falls while clock is high
   task automatic start();
      if (!scl) begin
         #50 sda_m = 1'b1;
         #150 scl = 1'b1;
      end
      #200 sda_m = 1'b0;
      #200 scl = 1'b0;
   endtask : start
   // Stop after any whole byte: data rises while clock is high
   task automatic stop();
      #50 sda_m = 1'b0;
      #150 scl = 1'b1;
      #200 sda_m = 1'b1;
      #200;
   endtask : stop
   // One bit; data moves well after the clock fall, sampled mid-high
   task automatic bit_slot(input logic b, output logic s);
      #50 sda_m = b;
      #150 scl = 1'b1;
      #100 s = sda_line;
      #100 scl = 1'b0;
   endtask : bit_slot
   // Byte out, most significant bit first, then the slave's answer
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(d[i], s);
      end
      bit_slot(1'b1, s);
      ack = ~s;
   endtask : wr_byte
   // Byte in; the last byte is answered with a not-acknowledge
   task automatic rd_byte(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(1'b1, s);
         d[i] = s;
      end
      bit_slot(last, s);
   endtask : rd_byte
endmodule : scs_host

// file: scs_config_slave_test.sv
// Self-checking bench: host model on the bus, stream collected and judged
`timescale 1ns/1ps
module scs_config_slave_test;
   localparam logic [7:0] AW = 8'h54;  // Default address, write
   localparam logic [7:0] AR = 8'h55;  // Default address, read
   logic             clk_sys = 1'b0;
   logic             clk_link = 1'b0;
   logic             sys_rst = 1'b1;
   logic             cfg_wr_ready = 1'b1;
   logic             scl;
   logic             sda_m;
   logic             sda_o;
   logic             sda_oe;
   logic             sda_line;
   logic             cfg_wr_valid;
   scs_pkg::scs_wr_t cfg_wr;
   scs_pkg::scs_wr_t got[$];
   int               bad_count = 0;
   int               cmp_count = 0;

   // System clock and a free link sampling clock of unrelated phase
   always #12.5 clk_sys = ~clk_sys;
   initial begin
      #4.1;
      forever #7.5 clk_link = ~clk_link;
   end
   // Open-drain data line with pull-up
   assign sda_line = sda_m & ~(sda_oe & ~sda_o);

   scs_config_slave u_dut (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_link(clk_link),
      .scl(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
      .cfg_wr_valid(cfg_wr_valid), .cfg_wr(cfg_wr),
      .cfg_wr_ready(cfg_wr_ready)
   );
   scs_host u_host (.sda_line(sda_line), .scl(scl), .sda_m(sda_m));

   // Collect every entry the stream hands over
   always @(posedge clk_sys) begin
      if (!sys_rst && cfg_wr_valid && cfg_wr_ready) begin
         got.push_back(cfg_wr);
      end
   end

   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] seen);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic put(input logic [7:0] d, input logic want);
      logic a;
      u_host.wr_byte(d, a);
      chk("ack", {15'h0, want}, {15'h0, a});
   endtask : put
   task automatic get(input logic last, input logic [7:0] exp);
      logic [7:0] d;
      u_host.rd_byte(last, d);
      chk("read", {8'h00, exp}, {8'h00, d});
   endtask : get
   // Waits a bounded time for the next stream entry
   task automatic take(input logic [6:0] ofs, input logic [7:0] d);
      scs_pkg::scs_wr_t e;
      e = '1;
      for (int n = 0; n < 400 && got.size() == 0; n++) begin
         @(negedge clk_sys);
      end
      if (got.size() > 0) e = got.pop_front();
      chk("entry", {1'b0, ofs, d}, {1'b0, e});
   endtask : take
   task automatic wr_setup(input logic [7:0] cmd);
      u_host.start();
      put(AW, 1'b1);
      put(cmd, 1'b1);
   endtask : wr_setup
   task automatic rd_setup(input logic [7:0] cmd);
      wr_setup(cmd);
      u_host.start();
      put(AR, 1'b1);
   endtask : rd_setup
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : conclude

   task automatic t_writes();
      wr_setup(8'h85);
      put(8'h3c, 1'b1);
      u_host.stop();
      take(7'h05, 8'h3c);
      wr_setup(8'h90);
      put(8'h11, 1'b1);
      put(8'h22, 1'b1);
      put(8'h33, 1'b0);
      u_host.stop();
      take(7'h10, 8'h11);
      take(7'h11, 8'h22);
      $display("Test indexed writes done");
   endtask : t_writes
   task automatic t_reads();
      rd_setup(8'h90);
      get(1'b0, 8'h11);
      get(1'b1, 8'h22);
      u_host.stop();
      rd_setup(8'h85);
      get(1'b1, 8'h3c);
      u_host.stop();
      $display("Test indexed reads done");
   endtask : t_reads
   task automatic t_blocks();
      logic [7:0] exp [8];
      exp = '{8'ha1, 8'ha2, 8'ha3, 8'h00, 8'h00, 8'h3c, 8'h00, 8'h00};
      wr_setup(8'h00);
      put(8'h03, 1'b1);
      for (int i = 0; i < 3; i++) begin
         put(8'(i) + 8'ha1, 1'b1);
      end
      put(8'ha4, 1'b0);
      u_host.stop();
      for (int i = 0; i < 3; i++) begin
         take(7'(i), 8'(i) + 8'ha1);
      end
      rd_setup(8'h00);
      get(1'b0, 8'h08);
      for (int i = 0; i < 8; i++) begin
         get(i == 7, exp[i]);
      end
      u_host.stop();
      $display("Test block transfers done");
   endtask : t_blocks
   task automatic t_abort();
      logic s;
      u_host.start();
      put(8'h56, 1'b0);
      u_host.stop();
      u_host.start();
      u_host.bit_slot(1'b0, s);
      u_host.bit_slot(1'b1, s);
      u_host.stop();
      wr_setup(8'h87);
      put(8'h5a, 1'b1);
      u_host.stop();
      take(7'h07, 8'h5a);
      $display("Test abort done");
   endtask : t_abort
   task automatic t_fill();
      @(negedge clk_sys) cfg_wr_ready = 1'b0;
      wr_setup(8'h00);
      // Count leaves room; the buffer plus output stage hold seventeen
      put(8'h20, 1'b1);
      for (int i = 0; i < 17; i++) begin
         put(8'(i) + 8'h40, 1'b1);
      end
      put(8'h60, 1'b0);
      u_host.stop();
      @(negedge clk_sys) cfg_wr_ready = 1'b1;
      for (int i = 0; i < 17; i++) begin
         take(7'(i), 8'(i) + 8'h40);
      end
      repeat (20) @(negedge clk_sys);
      chk("leftover", 16'h0000, 16'(got.size()));
      $display("Test buffer fill done");
   endtask : t_fill

   // Main sequence
   initial begin
      repeat (3) @(negedge clk_sys);
      sys_rst = 1'b0;
      repeat (10) @(negedge clk_sys);
      t_writes();
      t_reads();
      t_blocks();
      t_abort();
      t_fill();
      conclude();
   end
   // Watchdog well beyond the expected run of a few hundred microseconds
   initial begin
      #2_000_000;
      bad_count++;
      conclude();
   end
endmodule : scs_config_slave_test
